/* File: dead_time_pair.sv */
// Purpose: dead-time insertion for one even/odd output pair
// Assumes: tick is a one-cycle pulse from the prescaled time base
// Notes:   both outputs go low on every edge of level_in, the new one rises after the count
`timescale 1ns/100ps
`default_nettype none

module dead_time_pair
  import pwm_pkg::*;
(
  input  wire logic                     clk_sys,
  input  wire logic                     resetn,
  input  wire logic                     level_in,
  input  wire logic [pwm_pkg::DT_W-1:0] dead_value,
  input  wire logic                     tick,
  output logic                          even_out,
  output logic                          odd_out
);

  typedef struct packed {
    logic            prev;
    logic [DT_W-1:0] cnt;
    logic            even;
    logic            odd;
  } dt_state_type;

  dt_state_type s_q;
  dt_state_type s_d;

  always_comb
  begin
    s_d = s_q;
    s_d.prev = level_in;
    if (level_in != s_q.prev)
    begin
      // edge: reload and switch the active pin off first
      s_d.cnt  = dead_value;
      s_d.even = 1'b0;
      s_d.odd  = 1'b0;
    end
    else if (s_q.cnt != RST_DT)
    begin
      if (tick)
      begin
        s_d.cnt = s_q.cnt - 6'h01;
      end
    end
    else
    begin
      // count reached zero: let the delayed transition through
      s_d.even = s_q.prev;
      s_d.odd  = ~s_q.prev;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign even_out = s_q.even;
  assign odd_out  = s_q.odd;

endmodule // dead_time_pair

`default_nettype wire

/* File: half_bridge_model.sv */
// Purpose: half-bridge drivers on the eight pins
// Assumes: pairs are pins 2p and 2p+1
// Notes:   counts clocks in which a bridge would short
`timescale 1ns/100ps
`default_nettype none

module half_bridge_model
  import pwm_pkg::*;
(
  input  wire logic                        clk_sys,
  input  wire logic                        resetn,
  input  wire logic [pwm_pkg::NUM_PIN-1:0] pwm_pin,
  output var  int                          shoot_cnt
);
  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn)
      shoot_cnt <= 0;
    else if ((pwm_pin[7:1] & pwm_pin[6:0] & 7'h55) != 7'h00)
      shoot_cnt <= shoot_cnt + 1;
endmodule // half_bridge_model

`default_nettype wire

/* File: pwm_output_stage.sv */
// Purpose: four duty generators, eight pins, complementary pairs, dead time, override
// Assumes: single clock clk_sys, register port with read data one cycle later
// Notes:   pin outputs are registered; pins of a disabled channel are held low
`timescale 1ns/100ps
`default_nettype none

module pwm_output_stage
  import pwm_pkg::*;
(
  input  wire logic                       clk_sys,
  input  wire logic                       resetn,
  input  wire logic [pwm_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [pwm_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic      [pwm_pkg::DATA_W-1:0] reg_rdata,
  output logic      [pwm_pkg::NUM_PIN-1:0] pwm_pin
);

  typedef struct packed {
    logic                             run;
    logic [1:0]                       psel;
    logic [TIMER_W-1:0]               period;
    logic [NUM_GEN-1:0][TIMER_W-1:0]  duty;
    logic [NUM_PIN-1:0]               enable;
    logic [NUM_PIN-1:0]               ov_value;
    logic [NUM_PIN-1:0]               ov_mask;
    logic [DT_W-1:0]                  dt_low;
    logic [DT_W-1:0]                  dt_high;
    ta_state_type                     ta;
    logic [TA_CNT_W-1:0]              ta_cnt;
    logic [PRE_W-1:0]                 pre_cnt;
    logic                             tick;
    logic [TIMER_W-1:0]               timer;
    logic [NUM_GEN-1:0]               cmp;
    logic [NUM_PIN-1:0]               pins;
    logic [DATA_W-1:0]                rdata;
  } state_type;

  state_type s_q;
  state_type s_d;

  logic [NUM_GEN-1:0] pair_level;
  logic [NUM_GEN-1:0] pair_even;
  logic [NUM_GEN-1:0] pair_odd;

  // last prescaler count for a divider selection
  function automatic logic [PRE_W-1:0] pre_last(input logic [1:0] sel);
    logic [PRE_W-1:0] r;
    r = PRE_LAST_DIV1;
    unique case (sel)
      2'h0: r = PRE_LAST_DIV1;
      2'h1: r = PRE_LAST_DIV2;
      2'h2: r = PRE_LAST_DIV4;
      2'h3: r = PRE_LAST_DIV16;
    endcase
    return r;
  endfunction

  // duty comparison: zero stays low, all ones stays high
  function automatic logic duty_cmp(input logic [TIMER_W-1:0] duty,
                                    input logic [TIMER_W-1:0] timer);
    return (duty == DUTY_ALWAYS_HIGH) || (timer < duty);
  endfunction

  // byte address of a duty register half
  function automatic logic [ADDR_W-1:0] duty_addr(input int ch, input logic hi);
    return OFF_DUTY_BASE + ADDR_W'(2 * ch) + ADDR_W'(hi);
  endfunction

  // level into each dead-time unit: even override or comparator
  always_comb
  begin
    for (int p = 0; p < NUM_GEN; p++)
    begin
      if (s_q.ov_mask[2*p])
      begin
        pair_level[p] = s_q.ov_value[2*p];
      end
      else
      begin
        pair_level[p] = s_q.cmp[p];
      end
    end
  end

  for (genvar g = 0; g < NUM_GEN; g++)
  begin : g_pair
    dead_time_pair u_dead_time (
      .clk_sys    (clk_sys),
      .resetn     (resetn),
      .level_in   (pair_level[g]),
      .dead_value ((g < 2) ? s_q.dt_low : s_q.dt_high),
      .tick       (s_q.tick),
      .even_out   (pair_even[g]),
      .odd_out    (pair_odd[g])
    );
  end

  always_comb
  begin
    s_d = s_q;
    s_d.tick = 1'b0;
    s_d.rdata = RST_BYTE;

    // prescaler and 12-bit time base
    if (s_q.run)
    begin
      if (s_q.pre_cnt >= pre_last(s_q.psel))
      begin
        s_d.pre_cnt = '0;
        s_d.tick = 1'b1;
      end
      else
      begin
        s_d.pre_cnt = s_q.pre_cnt + 4'h1;
      end
      if (s_q.tick)
      begin
        if (s_q.timer >= s_q.period)
        begin
          s_d.timer = '0;
        end
        else
        begin
          s_d.timer = s_q.timer + 12'h001;
        end
      end
    end
    else
    begin
      s_d.pre_cnt = '0;
      s_d.timer = '0;
    end

    // four duty comparators
    for (int p = 0; p < NUM_GEN; p++)
    begin
      s_d.cmp[p] = duty_cmp(s_q.duty[p], s_q.timer);
    end

    // pin drive per pair
    for (int p = 0; p < NUM_GEN; p++)
    begin
      if (s_q.enable[2*p] && s_q.enable[2*p+1])
      begin
        // odd override bits ignored here
        s_d.pins[2*p]   = pair_even[p];
        s_d.pins[2*p+1] = pair_odd[p];
      end
      else
      begin
        for (int k = 0; k < 2; k++)
        begin
          if (!s_q.enable[2*p+k])
          begin
            s_d.pins[2*p+k] = 1'b0;
          end
          else if (s_q.ov_mask[2*p+k])
          begin
            s_d.pins[2*p+k] = s_q.ov_value[2*p+k];
          end
          else
          begin
            s_d.pins[2*p+k] = s_q.cmp[p];
          end
        end
      end
    end

    // timed-access window countdown
    if (s_q.ta == TA_OPEN)
    begin
      if (s_q.ta_cnt == '0)
      begin
        s_d.ta = TA_IDLE;
      end
      else
      begin
        s_d.ta_cnt = s_q.ta_cnt - 3'h1;
      end
    end

    // register writes
    if (reg_wr)
    begin
      if (reg_addr == OFF_CTRL)
      begin
        s_d.run  = reg_wdata[CTRL_RUN_BIT];
        s_d.psel = reg_wdata[CTRL_PSEL_LSB +: 2];
      end
      if (reg_addr == OFF_PERIOD_LO)
      begin
        s_d.period[DATA_W-1:0] = reg_wdata;
      end
      if (reg_addr == OFF_PERIOD_HI)
      begin
        s_d.period[TIMER_W-1:DATA_W] = reg_wdata[HI_NIBBLE_W-1:0];
      end
      for (int c = 0; c < NUM_GEN; c++)
      begin
        if (reg_addr == duty_addr(c, 1'b0))
        begin
          s_d.duty[c][DATA_W-1:0] = reg_wdata;
        end
        if (reg_addr == duty_addr(c, 1'b1))
        begin
          s_d.duty[c][TIMER_W-1:DATA_W] = reg_wdata[HI_NIBBLE_W-1:0];
        end
      end
      if (reg_addr == OFF_ENABLE)
      begin
        s_d.enable = reg_wdata;
      end
      if (reg_addr == OFF_OV_VALUE)
      begin
        s_d.ov_value = reg_wdata;
      end
      if (reg_addr == OFF_OV_MASK)
      begin
        s_d.ov_mask = reg_wdata;
      end
      if (reg_addr == OFF_TA_KEY)
      begin
        if (reg_wdata == TA_KEY_FIRST)
        begin
          s_d.ta = TA_HALF;
        end
        else if (reg_wdata == TA_KEY_SECOND && s_q.ta == TA_HALF)
        begin
          s_d.ta = TA_OPEN;
          s_d.ta_cnt = TA_WINDOW;
        end
        else
        begin
          s_d.ta = TA_IDLE;
        end
      end
      if (s_q.ta == TA_OPEN && reg_addr == OFF_DT_LOW)
      begin
        s_d.dt_low = reg_wdata[DT_W-1:0];
        s_d.ta = TA_IDLE;
      end
      if (s_q.ta == TA_OPEN && reg_addr == OFF_DT_HIGH)
      begin
        s_d.dt_high = reg_wdata[DT_W-1:0];
        s_d.ta = TA_IDLE;
      end
    end

    // register reads, data in the next cycle only
    if (reg_rd)
    begin
      if (reg_addr == OFF_CTRL)
      begin
        s_d.rdata[CTRL_RUN_BIT] = s_q.run;
        s_d.rdata[CTRL_PSEL_LSB +: 2] = s_q.psel;
      end
      if (reg_addr == OFF_PERIOD_LO)
      begin
        s_d.rdata = s_q.period[DATA_W-1:0];
      end
      if (reg_addr == OFF_PERIOD_HI)
      begin
        s_d.rdata[HI_NIBBLE_W-1:0] = s_q.period[TIMER_W-1:DATA_W];
      end
      for (int c = 0; c < NUM_GEN; c++)
      begin
        if (reg_addr == duty_addr(c, 1'b0))
        begin
          s_d.rdata = s_q.duty[c][DATA_W-1:0];
        end
        if (reg_addr == duty_addr(c, 1'b1))
        begin
          s_d.rdata[HI_NIBBLE_W-1:0] = s_q.duty[c][TIMER_W-1:DATA_W];
        end
      end
      if (reg_addr == OFF_ENABLE)
      begin
        s_d.rdata = s_q.enable;
      end
      if (reg_addr == OFF_OV_VALUE)
      begin
        s_d.rdata = s_q.ov_value;
      end
      if (reg_addr == OFF_OV_MASK)
      begin
        s_d.rdata = s_q.ov_mask;
      end
      if (reg_addr == OFF_DT_LOW)
      begin
        s_d.rdata[DT_W-1:0] = s_q.dt_low;
      end
      if (reg_addr == OFF_DT_HIGH)
      begin
        s_d.rdata[DT_W-1:0] = s_q.dt_high;
      end
      if (reg_addr == OFF_PIN_STAT)
      begin
        s_d.rdata = s_q.pins;
      end
      if (reg_addr == OFF_TIMER_LO)
      begin
        s_d.rdata = s_q.timer[DATA_W-1:0];
      end
      if (reg_addr == OFF_TIMER_HI)
      begin
        s_d.rdata[HI_NIBBLE_W-1:0] = s_q.timer[TIMER_W-1:DATA_W];
      end
      if (reg_addr == OFF_TA_STAT)
      begin
        s_d.rdata[0] = (s_q.ta == TA_OPEN);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      s_q          <= '0;
      s_q.period   <= RST_PERIOD;
      s_q.duty     <= {NUM_GEN{RST_DUTY}};
      s_q.ov_value <= RST_BYTE;
      s_q.ov_mask  <= RST_BYTE;
      s_q.dt_low   <= RST_DT;
      s_q.dt_high  <= RST_DT;
      s_q.ta       <= TA_IDLE;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign pwm_pin   = s_q.pins;

endmodule // pwm_output_stage

`default_nettype wire

/* File: pwm_output_stage_sva.sv */
// Purpose: port checks for the pwm output stage
// Assumes: shadow registers follow the register port
// Notes:   bound into pwm_output_stage below
`timescale 1ns/100ps
`default_nettype none

module pwm_output_stage_sva
  import pwm_pkg::*;
(
  input wire logic                        clk_sys,
  input wire logic                        resetn,
  input wire logic [pwm_pkg::ADDR_W-1:0]  reg_addr,
  input wire logic [pwm_pkg::DATA_W-1:0]  reg_wdata,
  input wire logic                        reg_wr,
  input wire logic                        reg_rd,
  input wire logic [pwm_pkg::DATA_W-1:0]  reg_rdata,
  input wire logic [pwm_pkg::NUM_PIN-1:0] pwm_pin
);
  logic [7:0] val_q;
  logic [7:0] msk_q;
  logic [7:0] en_q;
  logic [7:0] cv;
  logic [7:0] frc;
  logic [2:0] age_q;

  // shadows of value, mask, enable; age counts clocks since last change
  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn)
    begin
      val_q <= 8'h00;
      msk_q <= 8'h00;
      en_q  <= 8'h00;
      age_q <= 3'h0;
    end
    else if (reg_wr && reg_addr inside {OFF_OV_VALUE, OFF_OV_MASK, OFF_ENABLE})
    begin
      if (reg_addr == OFF_OV_VALUE)
        val_q <= reg_wdata;
      if (reg_addr == OFF_OV_MASK)
        msk_q <= reg_wdata;
      if (reg_addr == OFF_ENABLE)
        en_q <= reg_wdata;
      age_q <= 3'h0;
    end
    else if (age_q != 3'h7)
      age_q <= age_q + 3'h1;

  // pins that are forced and outside a complementary pair
  always_comb
  begin
    for (int p = 0; p < 4; p++)
    begin
      cv[2*p]   = en_q[2*p] & en_q[2*p+1];
      cv[2*p+1] = en_q[2*p] & en_q[2*p+1];
    end
  end
  assign frc = msk_q & en_q & ~cv;

  sequence rd_at(a);
    reg_rd && reg_addr == a;
  endsequence

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  no_shoot_a:
    assert property ((pwm_pin[7:1] & pwm_pin[6:0] & 7'h55) == 7'h00) else $error("pair pins high together");
  ov_value_a:
    assert property (rd_at(OFF_OV_VALUE) |=> reg_rdata == val_q) else $error("override value readback");
  ov_mask_a:
    assert property (rd_at(OFF_OV_MASK) |=> reg_rdata == msk_q) else $error("override mask readback");
  unmapped_rd_a:
    assert property (rd_at(5'h1F) |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  force_pin_a:
    assert property (age_q >= 3'h4 |-> ((pwm_pin ^ val_q) & frc) == 8'h00) else $error("forced pin wrong");
  disabled_low_a:
    assert property (age_q >= 3'h4 |-> (pwm_pin & ~en_q) == 8'h00) else $error("disabled pin driven");
  even_gap_a:
    assert property ($rose(pwm_pin[0]) |-> !$past(pwm_pin[1])) else $error("even on without gap");
  odd_gap_a:
    assert property ($rose(pwm_pin[1]) |-> !$past(pwm_pin[0])) else $error("odd on without gap");
endmodule // pwm_output_stage_sva

bind pwm_output_stage pwm_output_stage_sva i_sva (
  .clk_sys   (clk_sys),
  .resetn    (resetn),
  .reg_addr  (reg_addr),
  .reg_wdata (reg_wdata),
  .reg_wr    (reg_wr),
  .reg_rd    (reg_rd),
  .reg_rdata (reg_rdata),
  .pwm_pin   (pwm_pin)
);

`default_nettype wire

/* File: pwm_pkg.sv */
// Purpose: shared constants and types for the complementary pwm output stage
// Assumes: 8-bit register port, 5-bit register address
// Notes:   register offsets, field positions, reset values and timing counts
package pwm_pkg;

  localparam int NUM_GEN  = 4;
  localparam int NUM_PIN  = 8;
  localparam int TIMER_W  = 12;
  localparam int DT_W     = 6;
  localparam int DATA_W   = 8;
  localparam int ADDR_W   = 5;
  localparam int PRE_W    = 4;
  localparam int TA_CNT_W = 3;

  // register offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL      = 5'h00;
  localparam logic [ADDR_W-1:0] OFF_PERIOD_LO = 5'h01;
  localparam logic [ADDR_W-1:0] OFF_PERIOD_HI = 5'h02;
  localparam logic [ADDR_W-1:0] OFF_DUTY_BASE = 5'h03;
  localparam logic [ADDR_W-1:0] OFF_ENABLE    = 5'h0B;
  localparam logic [ADDR_W-1:0] OFF_OV_VALUE  = 5'h0C;
  localparam logic [ADDR_W-1:0] OFF_OV_MASK   = 5'h0D;
  localparam logic [ADDR_W-1:0] OFF_DT_LOW    = 5'h0E;
  localparam logic [ADDR_W-1:0] OFF_DT_HIGH   = 5'h0F;
  localparam logic [ADDR_W-1:0] OFF_TA_KEY    = 5'h10;
  localparam logic [ADDR_W-1:0] OFF_PIN_STAT  = 5'h11;
  localparam logic [ADDR_W-1:0] OFF_TIMER_LO  = 5'h12;
  localparam logic [ADDR_W-1:0] OFF_TIMER_HI  = 5'h13;
  localparam logic [ADDR_W-1:0] OFF_TA_STAT   = 5'h14;

  // control field positions
  localparam int CTRL_RUN_BIT  = 0;
  localparam int CTRL_PSEL_LSB = 1;
  localparam int HI_NIBBLE_W   = 4;

  // reset values
  localparam logic [DATA_W-1:0]  RST_BYTE   = 8'h00;
  localparam logic [TIMER_W-1:0] RST_PERIOD = 12'hFFF;
  localparam logic [TIMER_W-1:0] RST_DUTY   = 12'h000;
  localparam logic [DT_W-1:0]    RST_DT     = 6'h00;

  // duty value that holds the comparator permanently high
  localparam logic [TIMER_W-1:0] DUTY_ALWAYS_HIGH = 12'hFFF;

  // prescaler last count for divide by 1, 2, 4, 16
  localparam logic [PRE_W-1:0] PRE_LAST_DIV1  = 4'h0;
  localparam logic [PRE_W-1:0] PRE_LAST_DIV2  = 4'h1;
  localparam logic [PRE_W-1:0] PRE_LAST_DIV4  = 4'h3;
  localparam logic [PRE_W-1:0] PRE_LAST_DIV16 = 4'hF;

  // timed access unlock keys and open window count; the window stays open one clock longer than this count
  localparam logic [DATA_W-1:0]   TA_KEY_FIRST  = 8'hAA;
  localparam logic [DATA_W-1:0]   TA_KEY_SECOND = 8'h55;
  localparam logic [TA_CNT_W-1:0] TA_WINDOW     = 3'h4;

  typedef enum logic [1:0] {TA_IDLE, TA_HALF, TA_OPEN} ta_state_type;

endpackage

/* File: testbench.sv */
// Purpose: directed tests of the pwm output stage
// Assumes: 25 MHz clock, register port with one-cycle read data
// Notes:   dead-time gaps are checked in ranges
`timescale 1ns/100ps
`default_nettype none

module testbench;
  import pwm_pkg::*;
  logic               clk_sys = 1'b0;
  logic               resetn = 1'b0;
  logic [ADDR_W-1:0]  reg_addr = 5'h00;
  logic [DATA_W-1:0]  reg_wdata = 8'h00;
  logic               reg_wr = 1'b0;
  logic               reg_rd = 1'b0;
  logic [DATA_W-1:0]  reg_rdata;
  logic [NUM_PIN-1:0] pwm_pin;
  logic [7:0]         rv;
  logic [7:0]         rw;
  int                 shoot_cnt;
  int                 g;
  int                 n_errors = 0;
  int                 samples_checked = 0;

  always #20 clk_sys = ~clk_sys;

  pwm_output_stage i_dut (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd),
    .reg_rdata (reg_rdata),
    .pwm_pin   (pwm_pin)
  );

  half_bridge_model i_bridge (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .pwm_pin   (pwm_pin),
    .shoot_cnt (shoot_cnt)
  );

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic rdchk(input logic [4:0] a, input logic [7:0] e);
    rd(a, rv);
    chk(rv, e);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // clocks until pin b of pair 0 turns on
  task automatic gap(input int b);
    g = 0;
    while (pwm_pin[b] !== 1'b1 && g < 300)
    begin
      @(posedge clk_sys);
      #1;
      g++;
    end
  endtask

  task automatic t_reset;
    settle(1);
    chk(pwm_pin, 8'h00);
    rdchk(OFF_OV_VALUE, 8'h00);
    rdchk(OFF_OV_MASK, 8'h00);
    rdchk(5'h1F, 8'h00);
  endtask

  task automatic t_override;
    wr(OFF_ENABLE, 8'h55);
    wr(OFF_OV_MASK, 8'hFF);
    wr(OFF_OV_VALUE, 8'hA5);
    settle(3);
    chk(pwm_pin, 8'h05);
    rdchk(OFF_OV_VALUE, 8'hA5);
    wr(OFF_OV_VALUE, 8'h5A);
    settle(3);
    chk(pwm_pin, 8'h50);
    wr(OFF_DUTY_BASE, 8'hFF);
    wr(OFF_DUTY_BASE + 5'h01, 8'h0F);
    wr(OFF_OV_MASK, 8'hFE);
    settle(3);
    chk(pwm_pin, 8'h51);
  endtask

  task automatic t_unlock;
    wr(OFF_DT_LOW, 8'h05);
    rdchk(OFF_DT_LOW, 8'h00);
    wr(OFF_TA_KEY, TA_KEY_FIRST);
    wr(OFF_TA_KEY, TA_KEY_SECOND);
    wr(OFF_DT_LOW, 8'h05);
    rdchk(OFF_DT_LOW, 8'h05);
    wr(OFF_DT_LOW, 8'h09);
    rdchk(OFF_DT_LOW, 8'h05);
    // unlock again, let the window run out, then try a write
    wr(OFF_TA_KEY, TA_KEY_FIRST);
    wr(OFF_TA_KEY, TA_KEY_SECOND);
    rdchk(OFF_TA_STAT, 8'h01);
    settle(6);
    rdchk(OFF_TA_STAT, 8'h00);
    wr(OFF_DT_LOW, 8'h09);
    rdchk(OFF_DT_LOW, 8'h05);
  endtask

  task automatic t_dead;
    wr(OFF_CTRL, 8'h01);
    wr(OFF_OV_VALUE, 8'h00);
    wr(OFF_OV_MASK, 8'h03);
    wr(OFF_ENABLE, 8'h03);
    settle(20);
    chk({6'h00, pwm_pin[1:0]}, 8'h02);
    wr(OFF_OV_VALUE, 8'h01);
    gap(0);
    chk(8'(g >= 5 && g <= 11), 8'h01);
    chk({6'h00, pwm_pin[1:0]}, 8'h01);
    wr(OFF_OV_VALUE, 8'h00);
    gap(1);
    chk(8'(g >= 5 && g <= 11), 8'h01);
    wr(OFF_CTRL, 8'h03);
    wr(OFF_OV_VALUE, 8'h01);
    gap(0);
    chk(8'(g >= 10 && g <= 18), 8'h01);
  endtask

  task automatic t_timer;
    rd(OFF_TIMER_LO, rw);
    rd(OFF_TIMER_LO, rv);
    chk(8'(rv !== rw), 8'h01);
    chk(8'(shoot_cnt != 0), 8'h00);
  endtask

  task automatic give_verdict;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    t_reset();
    t_override();
    t_unlock();
    t_dead();
    t_timer();
    give_verdict();
  end

  initial
  begin
    #(40 * 20000);
    n_errors++;
    give_verdict();
  end
endmodule // testbench

`default_nettype wire
